// *** logic/pcd_clock_control.sv ***
// Function
// - reference divided by field plus one; locked
// - test register reads zero outside test mode
// - tolerance change flag, write-one clear
// - tolerance status read-only, zero in fallback
// - fallback change flag on entry and exit
// - fallback status shows lost reference
// - supply level sets reset and forced bits
// - enables gate lock and fallback interrupts
// - enable cannot clear while synth selected
// - narrow band auto read-only or software set
// - keep oscillator running in stop mode
// - fallback disable chooses fallback or reset
// - synth select refused while synth off
// - system clock source select priority
// - module clock source select, forced in fallback
// - low divider divides by twice field
// - divider change within one divided cycle
// - synth frequency from multiplier and divider
// - debug clock xtal halved or bus clock
// - fallback sources all clocks but the divided crystal from synth
// - hold select low while switching source
// - multiplier resets zero, locked when selected
module pcd_clock_control
  import pcd_pkg::*;
#(
  parameter int SW_CYCLES = SWITCH_CYCLES
) (
  input  wire logic       REF_CLK,
  input  wire logic       RST_B,
  input  wire logic       CE,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       XTAL_CLOCK,
  input  wire logic       SYNTH_OUTPUT_CLOCK,
  input  wire logic       SYNTH_WITHIN_TOL,
  input  wire logic       REF_CLOCK_LOST,
  input  wire logic       SYNTH_SUPPLY,
  input  wire logic       SPECIAL_MODE,
  input  wire logic       TEST_MODE,
  input  wire logic [7:0] TEST_OUTPUT_BITS,
  output logic            SYNTH_ENABLE,
  output logic            SYNTH_NARROW_BAND,
  output logic [REF_DIV_W-1:0] SYNTH_REF_DIVIDER,
  output logic [MULT_W-1:0]    SYNTH_MULTIPLIER,
  output logic            OSC_KEEP_RUNNING_STOP,
  output logic            CLOCK_MONITOR_RESET,
  output logic            FALLBACK_ACTIVE,
  output logic [1:0]      SYS_CLOCK_SOURCE,
  output logic            CLOCK_SELECT_OUT,
  output logic            CPU_STALL,
  output logic            MODULE_CLOCK_FROM_DIVIDED,
  output logic            DEBUG_FROM_BUS_CLOCK,
  output logic            DIVIDED_XTAL_CLOCK,
  output logic            CORE_SYSTEM_CLOCK,
  output logic            EXTERNAL_BUS_CLOCK,
  output logic            PERIPHERAL_BUS_CLOCK,
  output logic            LOW_RATE_MODULE_CLOCK,
  output logic            MODULE_CLOCK,
  output logic            DEBUG_LINK_CLOCK,
  output logic            IRQ
);
  initial begin
    if (SW_CYCLES < 1 || SW_CYCLES > 255) $error("pcd_clock_control: SW_CYCLES out of range");
  end

  // three-stage synchronisers for pins from outside the domain
  logic [2:0] sync_xtal, sync_synth, sync_tol, sync_lost, sync_sup;
  logic       xtal_lvl, synth_lvl, tol_lvl, lost_lvl, sup_lvl;
  logic       next_xtal_lvl, next_synth_lvl, next_tol_lvl, next_lost_lvl, next_sup_lvl;

  // a change counts once stages two and three agree
  always_comb begin
    next_xtal_lvl  = (sync_xtal[1] == sync_xtal[2]) ? sync_xtal[2] : xtal_lvl;
    next_synth_lvl = (sync_synth[1] == sync_synth[2]) ? sync_synth[2] : synth_lvl;
    next_tol_lvl   = (sync_tol[1] == sync_tol[2]) ? sync_tol[2] : tol_lvl;
    next_lost_lvl  = (sync_lost[1] == sync_lost[2]) ? sync_lost[2] : lost_lvl;
    next_sup_lvl   = (sync_sup[1] == sync_sup[2]) ? sync_sup[2] : sup_lvl;
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sync_xtal  <= 3'h0;
      sync_synth <= 3'h0;
      sync_tol   <= 3'h0;
      sync_lost  <= 3'h0;
      sync_sup   <= 3'h0;
      xtal_lvl   <= 1'b0;
      synth_lvl  <= 1'b0;
      tol_lvl    <= 1'b0;
      lost_lvl   <= 1'b0;
      sup_lvl    <= 1'b0;
    end else if (CE) begin
      sync_xtal  <= {sync_xtal[1:0], XTAL_CLOCK};
      sync_synth <= {sync_synth[1:0], SYNTH_OUTPUT_CLOCK};
      sync_tol   <= {sync_tol[1:0], SYNTH_WITHIN_TOL};
      sync_lost  <= {sync_lost[1:0], REF_CLOCK_LOST};
      sync_sup   <= {sync_sup[1:0], SYNTH_SUPPLY};
      xtal_lvl   <= next_xtal_lvl;
      synth_lvl  <= next_synth_lvl;
      tol_lvl    <= next_tol_lvl;
      lost_lvl   <= next_lost_lvl;
      sup_lvl    <= next_sup_lvl;
    end
  end

  // software registers
  logic [REF_DIV_W-1:0] ref_divider, next_ref_divider;
  logic [MULT_W-1:0]    synth_multiplier, next_synth_multiplier;
  logic [LOW_DIV_W-1:0] low_div_field, next_low_div_field;
  logic tolerance_irq_enable, synth_enable, auto_band, narrow_band_select;
  logic osc_keep_running_stop, fallback_irq_enable, fallback_disable, fb_dis_written;
  logic next_tolerance_irq_enable, next_synth_enable, next_auto_band, next_narrow_band_select;
  logic next_osc_keep_running_stop, next_fallback_irq_enable, next_fallback_disable, next_fb_dis_written;
  logic sys_clock_from_synth, sys_clock_from_divided, module_clock_from_divided;
  logic next_sys_clock_from_synth, next_sys_clock_from_divided, next_module_clock_from_divided;
  logic tolerance_change_flag, fallback_change_flag, fallback_active, tol_seen;
  logic next_tolerance_change_flag, next_fallback_change_flag, next_fallback_active, next_tol_seen;
  logic supply_seen, next_supply_seen;
  logic pll_within_tolerance;
  logic tol_changed, fb_changed;
  logic [7:0] next_rdata;

  // tolerance only meaningful with synth enabled and fallback inactive
  assign pll_within_tolerance = tol_lvl && synth_enable && !fallback_active;
  assign tol_changed = pll_within_tolerance != tol_seen;
  assign fb_changed  = next_fallback_active != fallback_active;

  // register writes, status tracking and supply forcing
  always_comb begin
    next_ref_divider               = ref_divider;
    next_synth_multiplier          = synth_multiplier;
    next_low_div_field             = low_div_field;
    next_tolerance_irq_enable      = tolerance_irq_enable;
    next_synth_enable              = synth_enable;
    next_auto_band                 = auto_band;
    next_narrow_band_select        = narrow_band_select;
    next_osc_keep_running_stop     = osc_keep_running_stop;
    next_fallback_irq_enable       = fallback_irq_enable;
    next_fallback_disable          = fallback_disable;
    next_fb_dis_written            = fb_dis_written;
    next_sys_clock_from_synth      = sys_clock_from_synth;
    next_sys_clock_from_divided    = sys_clock_from_divided;
    next_module_clock_from_divided = module_clock_from_divided;
    next_tolerance_change_flag     = tolerance_change_flag;
    next_fallback_change_flag      = fallback_change_flag;
    next_tol_seen                  = pll_within_tolerance;
    next_supply_seen               = sup_lvl;
    // loss of reference: fallback only if allowed
    next_fallback_active = lost_lvl && !fallback_disable;
    if (WR) begin
      case (ADDR)
        OFS_SYNTH_MULT: begin
          if (!sys_clock_from_synth) next_synth_multiplier = WDATA[MULT_W-1:0];
        end
        OFS_REF_DIVIDER: begin
          if (!sys_clock_from_synth) next_ref_divider = WDATA[REF_DIV_W-1:0];
        end
        OFS_SYNTH_FLAGS: begin
          if (WDATA[FLG_TOL_CHG]) next_tolerance_change_flag = 1'b0;
          if (WDATA[FLG_FB_CHG]) next_fallback_change_flag = 1'b0;
        end
        OFS_SYNTH_CTRL: begin
          next_tolerance_irq_enable  = WDATA[CTL_TOL_IE];
          if (WDATA[CTL_ENABLE] || !sys_clock_from_synth) next_synth_enable = WDATA[CTL_ENABLE];
          next_auto_band             = WDATA[CTL_AUTO];
          if (!WDATA[CTL_AUTO]) next_narrow_band_select = WDATA[CTL_NARROW];
          next_osc_keep_running_stop = WDATA[CTL_KEEP_OSC];
          next_fallback_irq_enable   = WDATA[CTL_FB_IE];
          // write-once in normal modes
          if (SPECIAL_MODE || !fb_dis_written) begin
            next_fallback_disable = WDATA[CTL_FB_DIS];
            next_fb_dis_written   = 1'b1;
          end
        end
        OFS_CLK_SELECT: begin
          if (!WDATA[SEL_SYNTH] || synth_enable) next_sys_clock_from_synth = WDATA[SEL_SYNTH];
          next_sys_clock_from_divided    = WDATA[SEL_DIVIDED];
          next_module_clock_from_divided = WDATA[SEL_MODULE];
        end
        OFS_LOW_DIV: next_low_div_field = WDATA[LOW_DIV_W-1:0];
        default: ;
      endcase
    end
    // auto bandwidth follows tolerance, read-only
    if (next_auto_band) next_narrow_band_select = pll_within_tolerance;
    // events set after write clears so a same-cycle event wins; fallback then clears tolerance
    if (tol_changed) next_tolerance_change_flag = 1'b1;
    if (fallback_active) next_tolerance_change_flag = 1'b0;
    if (fb_changed) next_fallback_change_flag = 1'b1;
    // supply low forces bits; rising supply restores reset state
    if (!sup_lvl) begin
      next_synth_enable         = 1'b0;
      next_tolerance_irq_enable = 1'b0;
      next_fallback_irq_enable  = 1'b0;
      next_fallback_disable     = 1'b1;
      next_sys_clock_from_synth = 1'b0;
    end else if (!supply_seen) begin
      next_synth_enable     = 1'b1;
      next_fallback_disable = 1'b0;
      next_fb_dis_written   = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ref_divider               <= '0;
      synth_multiplier          <= '0;
      low_div_field             <= '0;
      tolerance_irq_enable      <= 1'b0;
      synth_enable              <= 1'b0;
      auto_band                 <= RST_AUTO;
      narrow_band_select        <= 1'b0;
      osc_keep_running_stop     <= 1'b0;
      fallback_irq_enable       <= 1'b0;
      fallback_disable          <= 1'b1;
      fb_dis_written            <= 1'b0;
      sys_clock_from_synth      <= 1'b0;
      sys_clock_from_divided    <= 1'b0;
      module_clock_from_divided <= 1'b0;
      tolerance_change_flag     <= 1'b0;
      fallback_change_flag      <= 1'b0;
      fallback_active           <= 1'b0;
      tol_seen                  <= 1'b0;
      supply_seen               <= 1'b0;
    end else if (CE) begin
      ref_divider               <= next_ref_divider;
      synth_multiplier          <= next_synth_multiplier;
      low_div_field             <= next_low_div_field;
      tolerance_irq_enable      <= next_tolerance_irq_enable;
      synth_enable              <= next_synth_enable;
      auto_band                 <= next_auto_band;
      narrow_band_select        <= next_narrow_band_select;
      osc_keep_running_stop     <= next_osc_keep_running_stop;
      fallback_irq_enable       <= next_fallback_irq_enable;
      fallback_disable          <= next_fallback_disable;
      fb_dis_written            <= next_fb_dis_written;
      sys_clock_from_synth      <= next_sys_clock_from_synth;
      sys_clock_from_divided    <= next_sys_clock_from_divided;
      module_clock_from_divided <= next_module_clock_from_divided;
      tolerance_change_flag     <= next_tolerance_change_flag;
      fallback_change_flag      <= next_fallback_change_flag;
      fallback_active           <= next_fallback_active;
      tol_seen                  <= next_tol_seen;
      supply_seen               <= next_supply_seen;
    end
  end

  // read mux; latched control bits are returned, not forced outputs
  always_comb begin
    next_rdata = RST_ZERO;
    case (ADDR)
      OFS_SYNTH_MULT:  next_rdata[MULT_W-1:0] = synth_multiplier;
      OFS_REF_DIVIDER: next_rdata[REF_DIV_W-1:0] = ref_divider;
      OFS_TEST_REG:    next_rdata = TEST_MODE ? TEST_OUTPUT_BITS : RST_ZERO;
      OFS_SYNTH_FLAGS: begin
        next_rdata[FLG_TOL_CHG] = tolerance_change_flag;
        next_rdata[FLG_TOL]     = pll_within_tolerance;
        next_rdata[FLG_FB_CHG]  = fallback_change_flag;
        next_rdata[FLG_FB]      = fallback_active;
      end
      OFS_SYNTH_CTRL: begin
        next_rdata[CTL_TOL_IE]   = tolerance_irq_enable;
        next_rdata[CTL_ENABLE]   = synth_enable;
        next_rdata[CTL_AUTO]     = auto_band;
        next_rdata[CTL_NARROW]   = narrow_band_select;
        next_rdata[CTL_KEEP_OSC] = osc_keep_running_stop;
        next_rdata[CTL_FB_IE]    = fallback_irq_enable;
        next_rdata[CTL_FB_DIS]   = fallback_disable;
      end
      OFS_CLK_SELECT: begin
        next_rdata[SEL_SYNTH]   = sys_clock_from_synth;
        next_rdata[SEL_DIVIDED] = sys_clock_from_divided;
        next_rdata[SEL_MODULE]  = module_clock_from_divided;
      end
      OFS_LOW_DIV:     next_rdata[LOW_DIV_W-1:0] = low_div_field;
      default:         next_rdata = RST_ZERO;
    endcase
    if (!RD) next_rdata = RST_ZERO;
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) RDATA <= RST_ZERO;
    else if (CE) RDATA <= next_rdata;
  end

  // low-rate divider on crystal edges
  logic xtal_prev, xtal_rise, div_tick, div_level;
  assign xtal_rise = xtal_lvl && !xtal_prev;

  pcd_low_divider #(
    .DIV_W(LOW_DIV_W)
  ) u_low_divider (
    .clk      (REF_CLK),
    .rst_b    (RST_B),
    .ce       (CE),
    .xtal_tick((low_div_field == '0) ? (xtal_lvl != xtal_prev) : xtal_rise), // bypass: both edges
    .div_value(low_div_field),
    .div_tick (div_tick),
    .div_level(div_level)
  );

  // source selection with forced values in fallback
  pcd_src_type want_src, cur_src, next_cur_src;
  pcd_sw_type  sw_state, next_sw_state;
  logic [7:0]  sw_count, next_sw_count;

  always_comb begin
    if (fallback_active || sys_clock_from_synth) want_src = SRC_SYNTH;
    else if (sys_clock_from_divided) want_src = SRC_DIVIDED;
    else want_src = SRC_XTAL;
  end

  // switch: hold select low and stall for a settle period
  always_comb begin
    next_sw_state = sw_state;
    next_sw_count = sw_count;
    next_cur_src  = cur_src;
    case (sw_state)
      SW_IDLE: begin
        if (want_src != cur_src) begin
          next_sw_state = SW_HOLD;
          next_sw_count = '0;
        end
      end
      SW_HOLD: begin
        next_cur_src  = want_src;
        next_sw_state = SW_SETTLE;
      end
      SW_SETTLE: begin
        if (sw_count >= 8'(SW_CYCLES - 1)) next_sw_state = SW_IDLE;
        else next_sw_count = sw_count + 8'h01;
      end
      default: next_sw_state = SW_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sw_state  <= SW_IDLE;
      sw_count  <= 8'h00;
      cur_src   <= SRC_XTAL;
      xtal_prev <= 1'b0;
    end else if (CE) begin
      sw_state  <= next_sw_state;
      sw_count  <= next_sw_count;
      cur_src   <= next_cur_src;
      xtal_prev <= xtal_lvl;
    end
  end

  // derived clocks, rebuilt as sampled levels (toggle on source rising edges)
  logic sys_src, sys_prev, sys_rise, lr_src, lr_prev, lr_rise, x_prev2;
  logic half_sys, half_lr, half_xtal;
  logic next_half_sys, next_half_lr, next_half_xtal;

  always_comb begin
    case (cur_src)
      SRC_SYNTH:   sys_src = synth_lvl;
      SRC_DIVIDED: sys_src = div_level;
      default:     sys_src = xtal_lvl;
    endcase
    // in fallback the slow chain also runs from the synth
    lr_src = fallback_active ? synth_lvl : div_level;
  end

  assign sys_rise = sys_src && !sys_prev;
  assign lr_rise  = lr_src && !lr_prev;
  assign next_half_sys  = sys_rise ? ~half_sys : half_sys;
  assign next_half_lr   = lr_rise ? ~half_lr : half_lr;
  assign next_half_xtal = (fallback_active ? (synth_lvl && !x_prev2) : xtal_rise) ? ~half_xtal : half_xtal;

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sys_prev  <= 1'b0;
      lr_prev   <= 1'b0;
      x_prev2   <= 1'b0;
      half_sys  <= 1'b0;
      half_lr   <= 1'b0;
      half_xtal <= 1'b0;
    end else if (CE) begin
      sys_prev  <= sys_src;
      lr_prev   <= lr_src;
      x_prev2   <= synth_lvl;
      half_sys  <= next_half_sys;
      half_lr   <= next_half_lr;
      half_xtal <= next_half_xtal;
    end
  end

  // outputs; enable and select forced in fallback, module select forced low
  assign SYNTH_ENABLE              = synth_enable || fallback_active;
  assign SYNTH_NARROW_BAND         = narrow_band_select;
  assign SYNTH_REF_DIVIDER         = ref_divider;
  assign SYNTH_MULTIPLIER          = synth_multiplier;
  assign OSC_KEEP_RUNNING_STOP     = osc_keep_running_stop;
  assign CLOCK_MONITOR_RESET       = lost_lvl && fallback_disable;
  assign FALLBACK_ACTIVE           = fallback_active;
  assign SYS_CLOCK_SOURCE          = cur_src;
  assign CLOCK_SELECT_OUT          = (sw_state == SW_IDLE);
  assign CPU_STALL                 = (sw_state != SW_IDLE);
  assign MODULE_CLOCK_FROM_DIVIDED = module_clock_from_divided && !fallback_active;
  assign DEBUG_FROM_BUS_CLOCK      = !fallback_active && !sys_clock_from_synth && sys_clock_from_divided
                                     && (low_div_field != '0);
  assign DIVIDED_XTAL_CLOCK        = div_level;
  assign CORE_SYSTEM_CLOCK         = sys_src;
  assign EXTERNAL_BUS_CLOCK        = half_sys;
  assign PERIPHERAL_BUS_CLOCK      = half_sys;
  assign LOW_RATE_MODULE_CLOCK     = half_lr;
  assign MODULE_CLOCK              = MODULE_CLOCK_FROM_DIVIDED ? half_lr : half_sys;
  assign DEBUG_LINK_CLOCK          = DEBUG_FROM_BUS_CLOCK ? half_sys : half_xtal;
  assign IRQ = (tolerance_change_flag && tolerance_irq_enable)
               || (fallback_change_flag && fallback_irq_enable);
endmodule

// *** logic/pcd_low_divider.sv ***
module pcd_low_divider
  import pcd_pkg::*;
#(
  parameter int DIV_W = LOW_DIV_W
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             ce,
  input  wire logic             xtal_tick,
  input  wire logic [DIV_W-1:0] div_value,
  output logic                  div_tick,
  output logic                  div_level
);
  initial begin
    if (DIV_W < 1 || DIV_W > 16) $error("pcd_low_divider: DIV_W out of range");
  end

  logic [DIV_W-1:0] count;
  logic [DIV_W-1:0] next_count;
  logic             next_level;
  logic             next_tick;

  // half period is div_value ticks, so full period 2*value; value 0 bypasses
  always_comb begin
    next_count = count;
    next_level = div_level;
    next_tick  = 1'b0;
    if (xtal_tick) begin
      if (div_value == '0) begin
        next_count = '0;
        next_level = ~div_level;
        next_tick  = 1'b1;
      end else if (count >= div_value - 1'b1) begin // new value takes hold at once
        next_count = '0;
        next_level = ~div_level;
        next_tick  = 1'b1;
      end else begin
        next_count = count + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count     <= '0;
      div_level <= 1'b0;
      div_tick  <= 1'b0;
    end else if (ce) begin
      count     <= next_count;
      div_level <= next_level;
      div_tick  <= next_tick;
    end
  end
endmodule

// *** logic/pcd_pkg.sv ***
package pcd_pkg;
  // register offsets (byte addresses on the plain port)
  localparam logic [7:0] OFS_SYNTH_MULT   = 8'h38;
  localparam logic [7:0] OFS_REF_DIVIDER  = 8'h39;
  localparam logic [7:0] OFS_TEST_REG     = 8'h3A;
  localparam logic [7:0] OFS_SYNTH_FLAGS  = 8'h3B;
  localparam logic [7:0] OFS_SYNTH_CTRL   = 8'h3C;
  localparam logic [7:0] OFS_CLK_SELECT   = 8'h3D;
  localparam logic [7:0] OFS_LOW_DIV      = 8'h3E;
  // field widths
  localparam int REF_DIV_W  = 3;
  localparam int MULT_W     = 6;
  localparam int LOW_DIV_W  = 6;
  // synth_flags bit positions
  localparam int FLG_TOL_CHG  = 7;
  localparam int FLG_TOL      = 6;
  localparam int FLG_FB_CHG   = 1;
  localparam int FLG_FB       = 0;
  // synth_control bit positions
  localparam int CTL_TOL_IE   = 7;
  localparam int CTL_ENABLE   = 6;
  localparam int CTL_AUTO     = 5;
  localparam int CTL_NARROW   = 4;
  localparam int CTL_KEEP_OSC = 2;
  localparam int CTL_FB_IE    = 1;
  localparam int CTL_FB_DIS   = 0;
  // clock_source_select bit positions
  localparam int SEL_SYNTH    = 6;
  localparam int SEL_DIVIDED  = 5;
  localparam int SEL_MODULE   = 2;
  // reset values
  localparam logic [7:0] RST_ZERO   = 8'h00;
  localparam logic       RST_AUTO   = 1'b1;
  // clock source switch settle time
  localparam int SWITCH_TIME_NS = 40;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int SWITCH_CYCLES  = (SWITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // clock source choice
  typedef enum logic [1:0] {
    SRC_XTAL    = 2'b00,
    SRC_DIVIDED = 2'b01,
    SRC_SYNTH   = 2'b10
  } pcd_src_type;
  // switch state machine
  typedef enum logic [1:0] {
    SW_IDLE   = 2'b00,
    SW_HOLD   = 2'b01,
    SW_SETTLE = 2'b10
  } pcd_sw_type;
endpackage

// *** testbench/pcd_clock_asserts.sv ***
module pcd_clock_asserts
  import pcd_pkg::*;
(
  input wire logic       REF_CLK,
  input wire logic       RST_B,
  input wire logic       CE,
  input wire logic [7:0] ADDR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       TEST_MODE,
  input wire logic       SYNTH_SUPPLY,
  input wire logic       REF_CLOCK_LOST,
  input wire logic       SYNTH_ENABLE,
  input wire logic       CLOCK_MONITOR_RESET,
  input wire logic       FALLBACK_ACTIVE,
  input wire logic [1:0] SYS_CLOCK_SOURCE,
  input wire logic       CLOCK_SELECT_OUT,
  input wire logic       CPU_STALL,
  input wire logic       MODULE_CLOCK_FROM_DIVIDED
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  // relations
  chk_test_zero: assert property (RD && CE && ADDR == OFS_TEST_REG && !TEST_MODE |=> RDATA == 8'h00)
    else $error("test reg");
  chk_stall_inv: assert property (CPU_STALL == !CLOCK_SELECT_OUT)
    else $error("stall");
  chk_switch_low: assert property ($fell(CLOCK_SELECT_OUT) |-> !CLOCK_SELECT_OUT [*5] ##[1:20] CLOCK_SELECT_OUT)
    else $error("select span");
  chk_fb_enable: assert property (FALLBACK_ACTIVE |-> SYNTH_ENABLE)
    else $error("fb enable");
  chk_fb_module: assert property (FALLBACK_ACTIVE |-> !MODULE_CLOCK_FROM_DIVIDED)
    else $error("fb module");
  chk_fb_source: assert property (FALLBACK_ACTIVE [*8] |-> SYS_CLOCK_SOURCE == SRC_SYNTH)
    else $error("fb source");
  chk_supply_off: assert property ((!SYNTH_SUPPLY && !FALLBACK_ACTIVE) [*8] |-> !SYNTH_ENABLE)
    else $error("supply off");
  chk_mon_reset: assert property (CLOCK_MONITOR_RESET |-> REF_CLOCK_LOST)
    else $error("mon reset");
  chk_lost_fb: assert property (REF_CLOCK_LOST [*6] ##0 !CLOCK_MONITOR_RESET |-> ##[0:4] FALLBACK_ACTIVE)
    else $error("no fb");
  // scenarios
  cover property ($rose(FALLBACK_ACTIVE));
  cover property ($fell(CLOCK_SELECT_OUT));
  cover property (CLOCK_MONITOR_RESET);
endmodule
bind pcd_clock_control pcd_clock_asserts chk_u (.*);

// *** testbench/pcd_xtal_model.sv ***
module pcd_xtal_model (
  input  wire logic lost,
  input  wire logic enable,
  output logic      xtal,
  output logic      synth,
  output logic      tol
);
  timeunit 1ns;
  timeprecision 100ps;
  // crystal stops while lost
  initial xtal = 1'b0;
  always #40 xtal = lost ? xtal : ~xtal;
  // synth halts low when off
  initial synth = 1'b0;
  always #60 synth = enable ? ~synth : 1'b0;
  // lock lags enable
  initial tol = 1'b0;
  always @(enable) tol <= #500 enable;
endmodule

// *** testbench/tb_pll_clock_select_divider.sv ***
module tb_pll_clock_select_divider
  import pcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk, rst_b, wr_en, rd_en, lost, supply, test_mode;
  logic [7:0] addr, wdata, tbits, rdata;
  logic       xtal, synth, tol, sen, fba, cso, dxc, cmr, irq, osc, dbg;
  logic [1:0] src;
  int         err_total, comparisons;
  pcd_xtal_model part_u (.lost(lost), .enable(sen), .xtal(xtal), .synth(synth), .tol(tol));
  pcd_clock_control dut_u (.REF_CLK(clk), .RST_B(rst_b), .CE(1'b1), .ADDR(addr), .WDATA(wdata),
    .WR(wr_en), .RD(rd_en), .RDATA(rdata), .XTAL_CLOCK(xtal), .SYNTH_OUTPUT_CLOCK(synth),
    .SYNTH_WITHIN_TOL(tol), .REF_CLOCK_LOST(lost), .SYNTH_SUPPLY(supply), .SPECIAL_MODE(1'b0),
    .TEST_MODE(test_mode), .TEST_OUTPUT_BITS(tbits), .SYNTH_ENABLE(sen), .SYNTH_NARROW_BAND(),
    .SYNTH_REF_DIVIDER(), .SYNTH_MULTIPLIER(), .OSC_KEEP_RUNNING_STOP(osc), .CLOCK_MONITOR_RESET(cmr),
    .FALLBACK_ACTIVE(fba), .SYS_CLOCK_SOURCE(src), .CLOCK_SELECT_OUT(cso), .CPU_STALL(),
    .MODULE_CLOCK_FROM_DIVIDED(), .DEBUG_FROM_BUS_CLOCK(dbg), .DIVIDED_XTAL_CLOCK(dxc),
    .CORE_SYSTEM_CLOCK(), .EXTERNAL_BUS_CLOCK(), .PERIPHERAL_BUS_CLOCK(), .LOW_RATE_MODULE_CLOCK(),
    .MODULE_CLOCK(), .DEBUG_LINK_CLOCK(), .IRQ(irq));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic complete_run;
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] s, e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // one-cycle strobes
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    @(posedge clk);
    addr <= a; rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(rdata & m, e);
  endtask
  task automatic per(output logic [63:0] hi, p);
    time t0;
    repeat (2) @(posedge dxc);
    t0 = $time;
    @(negedge dxc);
    hi = $time - t0;
    @(posedge dxc);
    p = $time - t0;
  endtask
  task automatic wait_lock;
    for (int i = 0; i < 200 && tol !== 1'b1; i++) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask
  // partner crystal: 80 ns
  function automatic logic [63:0] div_period(input logic [7:0] v);
    return (v == 8'h00) ? 64'h50 : 64'hA0 * v;
  endfunction
  // watchdog
  initial begin
    #200000;
    err_total++;
    complete_run();
  end
  initial begin
    logic [7:0]  v;
    logic [63:0] hi, p;
    logic [7:0]  zl [7];
    logic [7:0]  dv [3];
    zl = '{OFS_SYNTH_MULT, OFS_REF_DIVIDER, OFS_TEST_REG, OFS_SYNTH_FLAGS, OFS_CLK_SELECT, OFS_LOW_DIV, 8'h40};
    dv = '{8'h00, 8'h01, 8'h3F};
    void'($urandom(51429));
    rst_b = 1'b0; wr_en = 1'b0; rd_en = 1'b0; addr = 8'h00; wdata = 8'h00; tbits = 8'h00;
    lost = 1'b0; supply = 1'b1; test_mode = 1'b0; err_total = 0; comparisons = 0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    reg_rd(OFS_SYNTH_CTRL, 8'h60);
    foreach (zl[i]) reg_rd(zl[i], 8'h00);
    reg_wr(OFS_SYNTH_CTRL, 8'hE0);
    v = 8'($urandom); test_mode <= 1'b1; tbits <= v;
    reg_rd(OFS_TEST_REG, v);
    test_mode <= 1'b0;
    repeat (4) begin
      v = 8'($urandom);
      reg_wr(OFS_LOW_DIV, v); reg_rd(OFS_LOW_DIV, {2'b00, v[5:0]});
      reg_wr(OFS_REF_DIVIDER, v); reg_rd(OFS_REF_DIVIDER, {5'h00, v[2:0]});
      reg_wr(OFS_SYNTH_MULT, v); reg_rd(OFS_SYNTH_MULT, {2'b00, v[5:0]});
    end
    foreach (dv[i]) begin
      reg_wr(OFS_LOW_DIV, dv[i]);
      per(hi, p);
      chk(p, div_period(dv[i]));
      chk(hi, div_period(dv[i]) / 2);
    end
    wait_lock();
    chk(irq, 1'b1);
    reg_rd(OFS_SYNTH_FLAGS, 8'hC0);
    reg_rd(OFS_SYNTH_CTRL, 8'hF0);
    reg_wr(OFS_SYNTH_FLAGS, 8'h80); reg_rd(OFS_SYNTH_FLAGS, 8'h40);
    chk(irq, 1'b0);
    reg_wr(OFS_SYNTH_CTRL, 8'hC0); reg_rd(OFS_SYNTH_CTRL, 8'hC0);
    reg_wr(OFS_SYNTH_CTRL, 8'hE0); reg_wr(OFS_REF_DIVIDER, 8'h05); reg_wr(OFS_SYNTH_MULT, 8'h11);
    reg_wr(OFS_CLK_SELECT, 8'h40);
    repeat (10) @(posedge clk);
    chk(src, SRC_SYNTH);
    reg_wr(OFS_REF_DIVIDER, 8'h02); reg_rd(OFS_REF_DIVIDER, 8'h05);
    reg_wr(OFS_SYNTH_MULT, 8'h3F); reg_rd(OFS_SYNTH_MULT, 8'h11);
    reg_wr(OFS_SYNTH_CTRL, 8'hA0); reg_rd(OFS_SYNTH_CTRL, 8'hF0);
    reg_wr(OFS_CLK_SELECT, 8'h20);
    repeat (10) @(posedge clk);
    chk(src, SRC_DIVIDED);
    chk(dbg, 1'b1);
    reg_wr(OFS_SYNTH_CTRL, 8'hA0); reg_wr(OFS_CLK_SELECT, 8'h60); reg_rd(OFS_CLK_SELECT, 8'h20);
    reg_wr(OFS_SYNTH_CTRL, 8'hE0);
    wait_lock();
    reg_wr(OFS_SYNTH_FLAGS, 8'h82); reg_wr(OFS_CLK_SELECT, 8'h04);
    lost <= 1'b1;
    for (int i = 0; i < 50 && fba !== 1'b1; i++) @(posedge clk);
    chk(fba, 1'b1);
    reg_rd(OFS_SYNTH_FLAGS, 8'h03);
    reg_rd(OFS_CLK_SELECT, 8'h04);
    reg_wr(OFS_SYNTH_CTRL, 8'h66); chk(osc, 1'b1);
    reg_wr(OFS_SYNTH_FLAGS, 8'h02); reg_rd(OFS_SYNTH_FLAGS, 8'h01);
    chk(irq, 1'b0);
    lost <= 1'b0;
    for (int i = 0; i < 50 && fba !== 1'b0; i++) @(posedge clk);
    reg_rd(OFS_SYNTH_FLAGS, 8'h02, 8'h03);
    chk(irq, 1'b1);
    supply <= 1'b0;
    repeat (10) @(posedge clk);
    lost <= 1'b1;
    repeat (10) @(posedge clk);
    chk(sen, 1'b0);
    chk(cmr, 1'b1);
    reg_rd(OFS_SYNTH_CTRL, 8'h25);
    complete_run();
  end
endmodule
